//--- rtl/fault_supervisor_pkg.sv
/*
 * Shared constants of the fault response supervisor: register offsets,
 * field positions, reset values, timing figures and the state encoding.
 * Assumes a 25 MHz internal clock; cycle counts derive from that rate.
 */
`default_nettype none

package fault_supervisor_pkg;

	// Register offsets (command codes from the management bus slave)
	localparam logic [7:0] FAULT_FLAGS_ADDR            = 8'hD0;
	localparam logic [7:0] FAULT_IGNORE_SELECT_ADDR    = 8'hD1;
	localparam logic [7:0] FAULT_RECOVERY_SELECT_ADDR  = 8'hD2;
	localparam logic [7:0] OUTPUT_OVER_THRESHOLD_ADDR  = 8'hD3;
	localparam logic [7:0] OUTPUT_UNDER_THRESHOLD_ADDR = 8'hD4;

	// Fault bit positions shared by flags, ignore and recovery registers
	localparam int INPUT_OV_BIT  = 2;
	localparam int OUTPUT_UV_BIT = 6;
	localparam int OUTPUT_OV_BIT = 7;

	// Reset values
	localparam logic [7:0] FAULT_FLAGS_RST            = 8'h00;
	localparam logic [7:0] FAULT_IGNORE_SELECT_RST    = 8'h40;
	localparam logic [7:0] OUTPUT_OVER_THRESHOLD_RST  = 8'h00;
	localparam logic [7:0] OUTPUT_UNDER_THRESHOLD_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_VALUE        = 8'h00;

	// Timing figures and derived cycle counts
	localparam int CLK_MHZ          = 25;
	localparam int IOV_QUAL_NS      = 5000;
	localparam int PG_DELAY_US      = 500;
	localparam int HICCUP_WAIT_MS   = 500;
	localparam int IOV_QUAL_CYC     = (IOV_QUAL_NS * CLK_MHZ + 999) / 1000;
	localparam int PG_DELAY_CYC     = PG_DELAY_US * CLK_MHZ;
	localparam int HICCUP_WAIT_CYC  = HICCUP_WAIT_MS * 1000 * CLK_MHZ;

	// Supervisor states
	typedef enum logic [2:0] {
		ST_OFF,
		ST_INIT,
		ST_RUN,
		ST_HICCUP,
		ST_LATCHED
	} sup_state_t;

endpackage : fault_supervisor_pkg

`default_nettype wire

//--- rtl/fault_response_supervisor.sv
/*
 * Fault response supervisor: synchronises the input overvoltage, output
 * undervoltage and output overvoltage comparators, qualifies the input
 * overvoltage by duration, keeps sticky fault
 * flags, drives the open-drain alert and power-good, and sequences
 * hiccup restart or latch-off.
 * Assumes a management bus slave upstream that hands over decoded command
 * codes with one-cycle read, write and clear-all strobes, and a soft-start
 * sequencer that reports the end of initialisation.
 */
`timescale 1ns/1ns
`default_nettype none

module fault_response_supervisor #(
	parameter int IOV_QUAL_CYCLES    = fault_supervisor_pkg::IOV_QUAL_CYC,
	parameter int PG_DELAY_CYCLES    = fault_supervisor_pkg::PG_DELAY_CYC,
	parameter int HICCUP_WAIT_CYCLES = fault_supervisor_pkg::HICCUP_WAIT_CYC
) (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       enable_in,
	input  wire logic       recovery_strap_pin,
	input  wire logic       init_done,
	input  wire logic       input_overvoltage,
	input  wire logic       output_undervoltage,
	input  wire logic       output_overvoltage,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	input  wire logic       clear_faults,
	output logic      [7:0] reg_rdata,
	output logic            switching_enable,
	output logic            soft_start_req,
	output logic            latched_off,
	output logic            power_ok_out,
	output logic            alert_n_out,
	output logic            alert_oe,
	output logic      [2:0] over_threshold_sel,
	output logic      [2:0] under_threshold_sel
);

	localparam int CNT_W = 24;

	// Comparator synchronisers
	logic [2:0] cmp_raw;
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;

	assign cmp_raw = {output_overvoltage, output_undervoltage, input_overvoltage};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sync
			always_ff @(posedge mclk)
			begin
				if (rst)
				begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
				end
				else
				begin
					sync1_q[gi] <= cmp_raw[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	logic iov_s;
	logic uv_s;
	logic oov_s;

	assign iov_s = sync2_q[0];
	assign uv_s  = sync2_q[1];
	assign oov_s = sync2_q[2];

	// Registers and state
	fault_supervisor_pkg::sup_state_t state_q;
	fault_supervisor_pkg::sup_state_t state_d;

	logic [7:0]       flags_q;
	logic [7:0]       flags_d;
	logic [7:0]       ignore_q;
	logic [7:0]       recovery_q;
	logic [7:0]       over_thr_q;
	logic [7:0]       under_thr_q;
	logic [CNT_W-1:0] qual_cnt_q;
	logic [CNT_W-1:0] pg_cnt_q;
	logic [CNT_W-1:0] hic_cnt_q;
	logic             iov_qual_q;

	// Register decode
	wire wr_flags = reg_write && (reg_addr == fault_supervisor_pkg::FAULT_FLAGS_ADDR);
	wire wr_ign   = reg_write && (reg_addr == fault_supervisor_pkg::FAULT_IGNORE_SELECT_ADDR);
	wire wr_rec   = reg_write && (reg_addr == fault_supervisor_pkg::FAULT_RECOVERY_SELECT_ADDR);
	wire wr_ovt   = reg_write && (reg_addr == fault_supervisor_pkg::OUTPUT_OVER_THRESHOLD_ADDR);
	wire wr_uvt   = reg_write && (reg_addr == fault_supervisor_pkg::OUTPUT_UNDER_THRESHOLD_ADDR);

	logic [7:0] rd_mux;
	assign rd_mux = (reg_addr == fault_supervisor_pkg::FAULT_FLAGS_ADDR)            ? flags_q     :
	                (reg_addr == fault_supervisor_pkg::FAULT_IGNORE_SELECT_ADDR)    ? ignore_q    :
	                (reg_addr == fault_supervisor_pkg::FAULT_RECOVERY_SELECT_ADDR)  ? recovery_q  :
	                (reg_addr == fault_supervisor_pkg::OUTPUT_OVER_THRESHOLD_ADDR)  ? over_thr_q  :
	                (reg_addr == fault_supervisor_pkg::OUTPUT_UNDER_THRESHOLD_ADDR) ? under_thr_q :
	                fault_supervisor_pkg::UNMAPPED_READ_VALUE;

	// fault detection (all three comparators) only in the run state, from soft-start on
	wire detect_on = (state_q == fault_supervisor_pkg::ST_RUN);

	wire iov_qual_hit = iov_s && (qual_cnt_q >= CNT_W'(IOV_QUAL_CYCLES - 1));

	// Detected fault events at their flag positions
	logic [7:0] event_vec;
	always_comb
	begin
		event_vec = 8'h00;
		event_vec[fault_supervisor_pkg::INPUT_OV_BIT]  = detect_on && iov_qual_q;
		event_vec[fault_supervisor_pkg::OUTPUT_UV_BIT] = detect_on && uv_s;
		event_vec[fault_supervisor_pkg::OUTPUT_OV_BIT] = detect_on && oov_s;
	end

	wire [7:0] trip_vec  = event_vec & ~ignore_q;
	wire       trip_any  = |trip_vec;
	// a zero recovery bit among tripped faults latches off
	wire       trip_latch = |(trip_vec & ~recovery_q);

	// restart held off while an unignored overvoltage persists
	wire restart_block = (iov_s && !ignore_q[fault_supervisor_pkg::INPUT_OV_BIT]) ||
	                     (oov_s && !ignore_q[fault_supervisor_pkg::OUTPUT_OV_BIT]);
	wire hic_done      = hic_cnt_q >= CNT_W'(HICCUP_WAIT_CYCLES - 1);

	// Fault flag next value: set wins over every clear
	wire [7:0] wr_clear = wr_flags ? reg_wdata : 8'h00;
	always_comb
	begin
		// clear by write-one, clear-all or enable low
		if (!enable_in || clear_faults)
			flags_d = 8'h00;
		else
			flags_d = flags_q & ~wr_clear;
		flags_d = flags_d | event_vec;
	end

	// Supervisor sequencing
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			fault_supervisor_pkg::ST_OFF:
				if (enable_in)
					state_d = fault_supervisor_pkg::ST_INIT;
			fault_supervisor_pkg::ST_INIT:
				if (init_done)
					state_d = fault_supervisor_pkg::ST_RUN;
			fault_supervisor_pkg::ST_RUN:
				if (trip_any)
					state_d = trip_latch ? fault_supervisor_pkg::ST_LATCHED : fault_supervisor_pkg::ST_HICCUP;
			fault_supervisor_pkg::ST_HICCUP:
				// restart after the hiccup wait once no unignored overvoltage persists
				if (hic_done && !restart_block)
					state_d = fault_supervisor_pkg::ST_RUN;
			// latch holds regardless of fault state
			fault_supervisor_pkg::ST_LATCHED:
				state_d = state_q;
		endcase
		if (!enable_in)
			state_d = fault_supervisor_pkg::ST_OFF;
	end

	wire enter_run = (state_d == fault_supervisor_pkg::ST_RUN) && (state_q != fault_supervisor_pkg::ST_RUN);

	// power-good delay runs while running and fault-free
	wire pg_clean  = (state_q == fault_supervisor_pkg::ST_RUN) && !iov_s && !uv_s && !oov_s;
	wire pg_done   = pg_cnt_q >= CNT_W'(PG_DELAY_CYCLES);

	// alert low during initialisation and while any flag set
	wire alert_low_d = (state_d == fault_supervisor_pkg::ST_INIT) || (|flags_d);

	// Registers written by the host
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			ignore_q    <= fault_supervisor_pkg::FAULT_IGNORE_SELECT_RST;
			recovery_q  <= {8{recovery_strap_pin}};
			over_thr_q  <= fault_supervisor_pkg::OUTPUT_OVER_THRESHOLD_RST;
			under_thr_q <= fault_supervisor_pkg::OUTPUT_UNDER_THRESHOLD_RST;
			reg_rdata   <= fault_supervisor_pkg::UNMAPPED_READ_VALUE;
		end
		else
		begin
			// undervoltage ignore set at reset, writable
			if (wr_ign)
				ignore_q <= reg_wdata;
			if (wr_rec)
				recovery_q <= reg_wdata;
			if (wr_ovt)
				over_thr_q <= reg_wdata;
			if (wr_uvt)
				under_thr_q <= reg_wdata;
			if (reg_read)
				reg_rdata <= rd_mux;
		end
	end

	// Flags, state and timers
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			flags_q    <= fault_supervisor_pkg::FAULT_FLAGS_RST;
			state_q    <= fault_supervisor_pkg::ST_OFF;
			qual_cnt_q <= '0;
			iov_qual_q <= 1'b0;
		end
		else
		begin
			flags_q    <= flags_d;
			state_q    <= state_d;
			qual_cnt_q <= (iov_s && !iov_qual_hit) ? qual_cnt_q + 1'b1 : (iov_s ? qual_cnt_q : '0);
			iov_qual_q <= iov_qual_hit;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			pg_cnt_q  <= '0;
			hic_cnt_q <= '0;
		end
		else
		begin
			pg_cnt_q  <= !pg_clean ? '0 : (pg_done ? pg_cnt_q : pg_cnt_q + 1'b1);
			// hiccup wait counter, repeats while blocked
			if ((state_q != fault_supervisor_pkg::ST_HICCUP) || hic_done)
				hic_cnt_q <= '0;
			else
				hic_cnt_q <= hic_cnt_q + 1'b1;
		end
	end

	// Registered outputs
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			switching_enable <= 1'b0;
			soft_start_req   <= 1'b0;
			latched_off      <= 1'b0;
			power_ok_out     <= 1'b0;
			alert_n_out      <= 1'b1;
			alert_oe         <= 1'b0;
		end
		else
		begin
			switching_enable <= (state_d == fault_supervisor_pkg::ST_RUN);
			soft_start_req   <= enter_run;
			latched_off      <= (state_d == fault_supervisor_pkg::ST_LATCHED);
			power_ok_out     <= pg_clean && pg_done && (state_d == fault_supervisor_pkg::ST_RUN);
			alert_n_out      <= !alert_low_d;
			alert_oe         <= alert_low_d;
		end
	end

	assign over_threshold_sel  = over_thr_q[2:0];
	assign under_threshold_sel = under_thr_q[2:0];

endmodule : fault_response_supervisor

`default_nettype wire

//--- bench/fault_supervisor_chk_sva.sv
/* Port checker for the fault response supervisor.
   Assumes a bind into the supervisor, one clock, synchronous reset. */
`timescale 1ns/1ns
`default_nettype none
module fault_supervisor_chk #(
	parameter int PG_DELAY_CYCLES = 20
) (
	input wire logic       mclk, rst, enable_in, reg_read, reg_write, clear_faults,
	input wire logic       input_overvoltage, output_undervoltage, output_overvoltage,
	input wire logic [7:0] reg_addr, reg_rdata,
	input wire logic       switching_enable, soft_start_req, latched_off, power_ok_out, alert_n_out
);
	int clean_q;
	wire logic clean_w = switching_enable && !input_overvoltage && !output_undervoltage && !output_overvoltage;
	always_ff @(posedge mclk)
		clean_q <= (rst || !clean_w) ? 0 : clean_q + 1;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	AST_PG_ONLY_RUN: assert property (power_ok_out |-> switching_enable)
		else $error("power good while stopped");
	AST_FLAG_ALERT: assert property (reg_read && reg_addr == 8'hD0 && enable_in && !clear_faults && !reg_write
		##1 reg_rdata != 8'h00 |-> !alert_n_out) else $error("alert released with flags set");
	AST_LATCH_HOLD: assert property (latched_off && enable_in |=> latched_off && !switching_enable)
		else $error("latch left without enable toggle");
	AST_ENABLE_EXIT: assert property (!enable_in ##1 !enable_in |=> !latched_off && !switching_enable)
		else $error("enable low did not clear latch");
	AST_RESTART_SS: assert property ($rose(switching_enable) |-> soft_start_req)
		else $error("restart without soft start");
	AST_OV_TRIP: assert property ((switching_enable && output_overvoltage) [*3] |-> ##3 !alert_n_out && !power_ok_out)
		else $error("overvoltage not reported");
	AST_UV_TRIP: assert property ((switching_enable && output_undervoltage) [*3] |-> ##3 !alert_n_out && !power_ok_out)
		else $error("undervoltage not reported");
	AST_PG_DELAY: assert property ($rose(power_ok_out) |-> clean_q >= PG_DELAY_CYCLES - 1)
		else $error("power good too early");
endmodule : fault_supervisor_chk
bind fault_response_supervisor fault_supervisor_chk #(.PG_DELAY_CYCLES(PG_DELAY_CYCLES)) chk (.mclk, .rst, .enable_in,
	.reg_read, .reg_write, .clear_faults, .input_overvoltage, .output_undervoltage, .output_overvoltage, .reg_addr,
	.reg_rdata, .switching_enable, .soft_start_req, .latched_off, .power_ok_out, .alert_n_out);
`default_nettype wire

//--- bench/mgmt_host_model.sv
/* Management host model: strobes register accesses at the falling edge.
   Assumes the supervisor takes strobes on rising mclk. */
`timescale 1ns/1ns
`default_nettype none
module mgmt_host_model (
	input  wire logic       mclk,
	input  wire logic [7:0] reg_rdata,
	output var logic  [7:0] reg_addr,
	output var logic  [7:0] reg_wdata,
	output var logic        reg_write,
	output var logic        reg_read,
	output var logic        clear_faults
);
	initial
	begin
		reg_addr = 8'hFF;
		reg_wdata = 8'h00;
		{clear_faults, reg_read, reg_write} = 3'h0;
	end
	task automatic access(input logic [7:0] a, input logic [7:0] d, input logic [2:0] kind, output logic [7:0] q);
		@(negedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		{clear_faults, reg_read, reg_write} <= kind;
		@(negedge mclk);
		q = reg_rdata;
		{clear_faults, reg_read, reg_write} <= 3'h0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : access
endmodule : mgmt_host_model
`default_nettype wire

//--- bench/tb_top.sv
/* Self-checking bench of the fault response supervisor.
   Assumes shortened timer parameters and a 25 MHz clock. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam int PG = 20;
	localparam int HIC = 50;
	logic mclk = 1'b0, rst, enable_in, recovery_strap_pin, init_done, input_overvoltage, output_undervoltage;
	logic output_overvoltage, reg_write, reg_read, clear_faults, switching_enable, soft_start_req;
	logic latched_off, power_ok_out, alert_n_out, alert_oe;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [2:0] over_threshold_sel, under_threshold_sel;
	int error_cnt = 0;
	int checks = 0;
	int n;
	logic [7:0] clr_q;
	always #20 mclk = ~mclk;
	fault_response_supervisor #(.IOV_QUAL_CYCLES(4), .PG_DELAY_CYCLES(PG), .HICCUP_WAIT_CYCLES(HIC)) dut (.mclk, .rst,
		.enable_in, .recovery_strap_pin, .init_done, .input_overvoltage, .output_undervoltage, .output_overvoltage,
		.reg_addr, .reg_wdata, .reg_write, .reg_read, .clear_faults, .reg_rdata, .switching_enable, .soft_start_req,
		.latched_off, .power_ok_out, .alert_n_out, .alert_oe, .over_threshold_sel, .under_threshold_sel);
	mgmt_host_model host (.mclk, .reg_rdata, .reg_addr, .reg_wdata, .reg_write, .reg_read, .clear_faults);
	task automatic cyc(input int c);
		repeat (c) @(negedge mclk);
	endtask : cyc
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic chkb(input string nm, input logic e, input logic g);
		chk(nm, {7'h00, e}, {7'h00, g});
	endtask : chkb
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		host.access(a, d, 3'h1, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		host.access(a, 8'h00, 3'h2, q);
		chk("reg_rdata", e, q);
	endtask : rd
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict
	initial
	begin
		cyc(3000);
		error_cnt++;
		print_verdict();
	end
	initial
	begin
		{rst, enable_in, recovery_strap_pin} = 3'h7;
		{init_done, input_overvoltage, output_undervoltage, output_overvoltage} = 4'h0;
		cyc(21);
		rst = 1'b0;
		rd(8'hD0, 8'h00);
		rd(8'hD1, 8'h40);
		rd(8'hD2, 8'hFF);
		rd(8'hD5, 8'h00);
		wr(8'hD3, 8'h07);
		wr(8'hD4, 8'h05);
		rd(8'hD3, 8'h07);
		chk("over_threshold_sel", 8'h07, {5'h00, over_threshold_sel});
		chk("under_threshold_sel", 8'h05, {5'h00, under_threshold_sel});
		chkb("alert_n_out", 1'b0, alert_n_out);
		output_overvoltage = 1'b1;
		cyc(10);
		output_overvoltage = 1'b0;
		rd(8'hD0, 8'h00);
		init_done = 1'b1;
		cyc(4);
		chkb("alert_n_out", 1'b1, alert_n_out);
		chkb("alert_oe", 1'b0, alert_oe);
		cyc(PG + 5);
		chkb("power_ok_out", 1'b1, power_ok_out);
		$display("test start done");
		output_undervoltage = 1'b1;
		cyc(6);
		chkb("switching_enable", 1'b1, switching_enable);
		chkb("power_ok_out", 1'b0, power_ok_out);
		output_undervoltage = 1'b0;
		rd(8'hD0, 8'h40);
		cyc(PG + 5);
		chkb("power_ok_out", 1'b1, power_ok_out);
		chkb("alert_n_out", 1'b0, alert_n_out);
		wr(8'hD0, 8'h40);
		rd(8'hD0, 8'h00);
		chkb("alert_n_out", 1'b1, alert_n_out);
		$display("test undervoltage done");
		output_overvoltage = 1'b1;
		cyc(6);
		chkb("switching_enable", 1'b0, switching_enable);
		rd(8'hD0, 8'h80);
		cyc(HIC + 10);
		chkb("switching_enable", 1'b0, switching_enable);
		output_overvoltage = 1'b0;
		n = 0;
		while (soft_start_req !== 1'b1 && n < HIC + 20)
		begin
			cyc(1);
			n++;
		end
		chkb("soft_start_req", 1'b1, soft_start_req);
		cyc(PG + 5);
		chkb("power_ok_out", 1'b1, power_ok_out);
		host.access(8'h00, 8'h00, 3'h4, clr_q);
		rd(8'hD0, 8'h00);
		$display("test hiccup done");
		wr(8'hD2, 8'h7B);
		input_overvoltage = 1'b1;
		cyc(3);
		input_overvoltage = 1'b0;
		rd(8'hD0, 8'h00);
		input_overvoltage = 1'b1;
		cyc(12);
		input_overvoltage = 1'b0;
		chkb("latched_off", 1'b1, latched_off);
		cyc(HIC + 20);
		chkb("switching_enable", 1'b0, switching_enable);
		rd(8'hD0, 8'h04);
		enable_in = 1'b0;
		cyc(3);
		chkb("latched_off", 1'b0, latched_off);
		rd(8'hD0, 8'h00);
		enable_in = 1'b1;
		cyc(10);
		chkb("switching_enable", 1'b1, switching_enable);
		$display("test latch done");
		wr(8'hD1, 8'h80);
		output_overvoltage = 1'b1;
		cyc(6);
		chkb("switching_enable", 1'b1, switching_enable);
		rd(8'hD0, 8'h80);
		output_overvoltage = 1'b0;
		$display("test ignore done");
		wr(8'hD1, 8'h40);
		wr(8'hD2, 8'hFF);
		input_overvoltage = 1'b1;
		cyc(12);
		chkb("power_ok_out", 1'b0, power_ok_out);
		chkb("switching_enable", 1'b0, switching_enable);
		chkb("alert_n_out", 1'b0, alert_n_out);
		rd(8'hD0, 8'h84);
		input_overvoltage = 1'b0;
		n = 0;
		while (soft_start_req !== 1'b1 && n < HIC + 20)
		begin
			cyc(1);
			n++;
		end
		chkb("soft_start_req", 1'b1, soft_start_req);
		$display("test input overvoltage done");
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
